// File: verilog/fbe_flash.sv
// Flash end: command decode, power-on state and factory boost erase
// Overview of operation
// - Boost erase only for full erase after arm
// - Host orders write permit, arm, erase
// - Arm command is its own select frame
// - Armed flag cleared at power-up and erase end
// - Power-up lands in standby, not deep down
// - Write permit latch cleared at power-up
// - Host keeps device deselected during power ramps
// - Below lockout: logic reset, commands ignored
// - Host waits settle before modifying commands
// - Reads accepted once supply settled
// - Falling below lockout aborts everything
`timescale 1ns/1ps
`default_nettype none
module fbe_flash
	import fbe_pkg::*;
#(
	parameter int SETTLE_CYCLES = SETTLE_CYC,
	parameter int STD_CYCLES    = ERASE_STD_CYC,
	parameter int BOOST_CYCLES  = ERASE_BOOST_CYC
) (
	input  wire logic mclk,
	input  wire logic nrst,
	input  wire logic supply_ok,
	fbe_link_if.dev   link,
	output var  logic busy,
	output var  logic boost_armed,
	output var  logic write_permit_latch,
	output var  logic ready,
	output var  logic deep_down,
	output var  logic erase_done,
	output var  logic erase_boosted
);
	// Refuse counts that the counters cannot serve
	if (SETTLE_CYCLES < 1 ||
			SETTLE_CYCLES >= (1 << CNT_W)) begin : g_bad_settle
		$error("fbe_flash: settle count out of range");
	end
	if (STD_CYCLES < 1 ||
			STD_CYCLES >= (1 << CNT_W)) begin : g_bad_std
		$error("fbe_flash: standard erase count out of range");
	end
	if (BOOST_CYCLES < 1 ||
			BOOST_CYCLES >= (1 << CNT_W)) begin : g_bad_boost
		$error("fbe_flash: boost erase count out of range");
	end

	// True when a captured byte matches the given opcode
	function automatic logic fbe_is_op(
		input logic [7:0] got,
		input logic [7:0] code
	);
		return got == code;
	endfunction

	logic             sclk_q;
	logic             cs_q;
	logic [7:0]       shreg;
	logic [3:0]       nbits;
	logic [CNT_W-1:0] settle_cnt;
	logic [CNT_W-1:0] erase_cnt;
	logic [7:0]       status_sh;
	logic [7:0]       status_word;

	// Lockout acts as a synchronous reset of all state but the edge detectors and opcode shifter
	wire             live            = supply_ok;
	wire             rise            = link.sclk & ~sclk_q;
	wire             fall            = ~link.sclk & sclk_q;
	wire             frame_end       = link.cs_n & ~cs_q;
	wire             in_frame        = live && !link.cs_n;
	wire [7:0]       next_sh         = {shreg[6:0], link.sdi};
	wire [3:0]       next_nbits      = (nbits == OP_BITS_MAX) ? nbits :
			nbits + 4'h1;
	// A command counts only when the frame held exactly one byte
	wire             byte_ok         = frame_end && nbits == OP_BITS;
	wire             accept          = live && ready && !busy &&
			byte_ok;
	wire             awake           = accept && !deep_down;
	wire             do_wp           = awake &&
			fbe_is_op(shreg, OPC_WRITE_PERMIT);
	wire             do_arm          = awake &&
			fbe_is_op(shreg, OPC_BOOST_ARM);
	wire             do_erase        = awake && write_permit_latch &&
			fbe_is_op(shreg, OPC_FULL_ERASE);
	wire             do_dp           = awake &&
			fbe_is_op(shreg, OPC_DEEP_DOWN);
	wire             do_rel          = accept &&
			fbe_is_op(shreg, OPC_RELEASE);
	wire             erase_end       = busy && erase_cnt == '0;
	wire [CNT_W-1:0] erase_len       = boost_armed ?
			CNT_W'(BOOST_CYCLES - 1) :
			CNT_W'(STD_CYCLES - 1);
	wire [CNT_W-1:0] next_settle_cnt = settle_cnt + CNT_W'(1);
	wire [CNT_W-1:0] next_erase_cnt  = erase_cnt - CNT_W'(1);
	wire             settle_last     = settle_cnt ==
			CNT_W'(SETTLE_CYCLES - 1);
	// Status is captured as the last opcode bit arrives
	wire             status_hit      = rise &&
			nbits == OP_BITS - 4'h1 &&
			fbe_is_op(next_sh, OPC_READ_STATUS) &&
			ready && !deep_down;
	wire             status_shift    = fall && nbits >= OP_BITS;

	// Status byte: armed flag, permit latch and busy, rest zero
	always_comb begin
		status_word                = 8'h00;
		status_word[ST_BUSY_BIT]   = busy;
		status_word[ST_PERMIT_BIT] = write_permit_latch;
		status_word[ST_ARMED_BIT]  = boost_armed;
	end

	// Edge detectors rest at the quiet levels of the link
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sclk_q <= 1'b0;
			cs_q   <= 1'b1;
		end else begin
			sclk_q <= link.sclk;
			cs_q   <= link.cs_n;
		end
	end

	// Opcode bits enter MSB first on each link clock rise
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			shreg <= 8'h00;
		else if (in_frame && rise)
			shreg <= next_sh;
	end

	// Count saturates so a long frame never passes as one opcode
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			nbits <= 4'h0;
		else if (!in_frame)
			nbits <= 4'h0;
		else if (rise)
			nbits <= next_nbits;
	end

	// Supply settle timer; reads and writes wait for it
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			settle_cnt <= '0;
			ready      <= 1'b0;
		end else if (!live) begin
			settle_cnt <= '0;
			ready      <= 1'b0;
		end else if (!ready) begin
			settle_cnt <= next_settle_cnt;
			ready      <= settle_last;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			write_permit_latch <= 1'b0;
		else if (!live)
			write_permit_latch <= 1'b0;
		else if (do_erase)
			write_permit_latch <= 1'b0;
		else if (do_wp)
			write_permit_latch <= 1'b1;
	end

	// Arm flag lasts until the next erase completes
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			boost_armed <= 1'b0;
		else if (!live)
			boost_armed <= 1'b0;
		else if (erase_end)
			boost_armed <= 1'b0;
		else if (do_arm)
			boost_armed <= 1'b1;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			deep_down <= 1'b0;
		else if (!live)
			deep_down <= 1'b0;
		else if (do_dp)
			deep_down <= 1'b1;
		else if (do_rel)
			deep_down <= 1'b0;
	end

	// Erase timer; the length is fixed when the erase starts
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			busy      <= 1'b0;
			erase_cnt <= '0;
		end else if (!live) begin
			busy      <= 1'b0;
			erase_cnt <= '0;
		end else if (do_erase) begin
			busy      <= 1'b1;
			erase_cnt <= erase_len;
		end else if (erase_end) begin
			busy <= 1'b0;
		end else if (busy) begin
			erase_cnt <= next_erase_cnt;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			erase_done <= 1'b0;
		else if (!live)
			erase_done <= 1'b0;
		else
			erase_done <= erase_end;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			erase_boosted <= 1'b0;
		else if (!live)
			erase_boosted <= 1'b0;
		else if (do_erase)
			erase_boosted <= boost_armed;
	end

	// Status byte leaves MSB first on the falls after the opcode
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			status_sh <= 8'h00;
		else if (!in_frame)
			status_sh <= 8'h00;
		else if (status_hit)
			status_sh <= status_word;
		else if (status_shift)
			status_sh <= {status_sh[6:0], 1'b0};
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			link.sdo <= 1'b0;
		else if (!in_frame)
			link.sdo <= 1'b0;
		else if (status_shift)
			link.sdo <= status_sh[7];
	end
endmodule
`default_nettype wire

// File: verilog/fbe_pkg.sv
// Shared constants for the factory boost erase link
`default_nettype none
package fbe_pkg;
	localparam int          OPC_W           = 8;
	localparam logic [7:0]  OPC_WRITE_PERMIT = 8'h06;
	localparam logic [7:0]  OPC_BOOST_ARM   = 8'h5A;
	localparam logic [7:0]  OPC_FULL_ERASE  = 8'hC7;
	localparam logic [7:0]  OPC_READ_STATUS = 8'h05;
	localparam logic [7:0]  OPC_DEEP_DOWN   = 8'hB9;
	localparam logic [7:0]  OPC_RELEASE     = 8'hAB;
	localparam int          CLK_NS          = 8;
	// Supply settle delay, in microseconds
	localparam int          SETTLE_US       = 800;
	localparam int          SETTLE_CYC      = (SETTLE_US * 1000) / CLK_NS;
	// Erase durations in cycles (simulation scale defaults)
	localparam int          ERASE_STD_CYC   = 2000;
	localparam int          ERASE_BOOST_CYC = 500;
	localparam int          SCLK_DIV        = 4;
	localparam int          CNT_W           = 24;
	// Opcode frame length and status byte layout
	localparam logic [3:0]  OP_BITS         = 4'h8;
	localparam logic [3:0]  OP_BITS_MAX     = 4'hF;
	localparam int          ST_BUSY_BIT     = 0;
	localparam int          ST_PERMIT_BIT   = 1;
	localparam int          ST_ARMED_BIT    = 2;
endpackage
`default_nettype wire

// File: verilog/fbe_link_if.sv
// Serial command link between host controller and flash device
`timescale 1ns/1ps
`default_nettype none
interface fbe_link_if;
	logic cs_n;
	logic sclk;
	logic sdi;
	logic sdo;
	modport host (output cs_n, output sclk, output sdi, input sdo);
	modport dev  (input cs_n, input sclk, input sdi, output sdo);
endinterface
`default_nettype wire

// File: verilog/fbe_host.sv
// Host end: sends one command frame per request, two bytes for a status read
`timescale 1ns/1ps
`default_nettype none
module fbe_host
	import fbe_pkg::*;
#(
	parameter int SETTLE_CYCLES = SETTLE_CYC
) (
	input  wire logic       mclk,
	input  wire logic       nrst,
	input  wire logic       supply_ok,
	input  wire logic       cmd_valid,
	input  wire logic [7:0] cmd_op,
	output var  logic       cmd_ready,
	output var  logic       cmd_done,
	output var  logic [7:0] rsp_byte,
	fbe_link_if.host        link
);
	initial begin
		if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << CNT_W))
			$error("fbe_host: settle count out of range");
	end

	typedef enum logic [1:0] {FH_WAIT, FH_IDLE, FH_SHIFT, FH_END} fh_state_t;
	fh_state_t        state;
	logic [CNT_W-1:0] cnt;
	logic [7:0]       tx;
	logic [4:0]       nbits;
	logic [2:0]       div;
	// Status read adds a second byte to capture the answer
	logic             two_bytes;

	wire settled  = cnt == CNT_W'(SETTLE_CYCLES - 1);
	wire half     = div == 3'(SCLK_DIV - 1);
	wire last_bit = nbits == (two_bytes ? 5'd16 : 5'd8);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state     <= FH_WAIT;
			cnt       <= '0;
			tx        <= 8'h00;
			nbits     <= 5'h00;
			div       <= 3'h0;
			two_bytes <= 1'b0;
			cmd_ready <= 1'b0;
			cmd_done  <= 1'b0;
			rsp_byte  <= 8'h00;
			link.cs_n <= 1'b1;
			link.sclk <= 1'b0;
			link.sdi  <= 1'b0;
		end else begin
			cmd_done <= 1'b0;
			if (!supply_ok) begin
				// Deselected while supply is absent
				state     <= FH_WAIT;
				cnt       <= '0;
				cmd_ready <= 1'b0;
				link.cs_n <= 1'b1;
				link.sclk <= 1'b0;
			end else begin
				case (state)
				FH_WAIT: begin
					cnt <= cnt + CNT_W'(1);
					if (settled) begin
						state     <= FH_IDLE;
						cmd_ready <= 1'b1;
					end
				end
				FH_IDLE: begin
					if (cmd_valid) begin
						// Each opcode gets its own frame
						state     <= FH_SHIFT;
						cmd_ready <= 1'b0;
						tx        <= {cmd_op[6:0], 1'b0};
						link.sdi  <= cmd_op[7];
						two_bytes <= cmd_op == OPC_READ_STATUS;
						link.cs_n <= 1'b0;
						nbits     <= 5'h00;
						div       <= 3'h0;
					end
				end
				FH_SHIFT: begin
					div <= half ? 3'h0 : div + 3'h1;
					if (half) begin
						if (!link.sclk) begin
							link.sclk <= 1'b1;
							nbits     <= nbits + 5'h1;
							rsp_byte  <= {rsp_byte[6:0], link.sdo};
						end else begin
							link.sclk <= 1'b0;
							if (last_bit) begin
								state <= FH_END;
							end else begin
								link.sdi <= tx[7];
								tx       <= {tx[6:0], 1'b0};
							end
						end
					end
				end
				FH_END: begin
					link.cs_n <= 1'b1;
					cmd_done  <= 1'b1;
					cmd_ready <= 1'b1;
					state     <= FH_IDLE;
				end
				default: state <= FH_WAIT;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// File: test/fbe_checker.sv
// Assertions on the link wires and flash status
`timescale 1ns/1ps
`default_nettype none
module fbe_checker (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic supply_ok,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic busy,
	input wire logic boost_armed,
	input wire logic write_permit_latch,
	input wire logic ready,
	input wire logic deep_down,
	input wire logic erase_done
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	lock_clr_a: assert property (!supply_ok |=> !boost_armed && !ready
		&& !write_permit_latch) else $error("lockout kept state");
	lock_stop_a: assert property (!supply_ok |=> !busy)
		else $error("erase survived lockout");
	standby_a: assert property ($rose(ready) |-> !deep_down)
		else $error("power-up in deep down");
	done_clr_a: assert property (erase_done |-> !boost_armed)
		else $error("arm kept after erase");
	done_end_a: assert property ($fell(busy) && $past(supply_ok)
		|-> erase_done) else $error("erase end without done");
	boost_len_a: assert property ($rose(busy) && boost_armed
		|-> busy[*5] ##1 !busy) else $error("boost erase length");
	csn_lock_a: assert property (!supply_ok |=> cs_n)
		else $error("selected in lockout");
	sclk_idle_a: assert property (cs_n |-> !sclk)
		else $error("clock outside frame");
	cover property ($rose(busy) && boost_armed);
	cover property ($rose(busy) && !boost_armed);
	cover property (erase_done);
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for host and flash ends
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import fbe_pkg::*;
	logic       mclk, nrst, supply_ok, cmd_valid, cmd_ready, cmd_done;
	logic       busy, boost_armed, write_permit_latch, ready, pb;
	logic       deep_down, erase_done, erase_boosted;
	logic [7:0] cmd_op, rsp_byte, op;
	int         error_cnt, n_compared, bcnt, armed, permit, seed;
	// Expected status bytes, queued when a status read is issued
	logic [7:0] exp_q[$];
	fbe_link_if lnk();
	fbe_flash #(.SETTLE_CYCLES(20), .STD_CYCLES(20), .BOOST_CYCLES(5))
	fbe_flash_i (.mclk, .nrst, .supply_ok, .link(lnk.dev), .busy,
		.boost_armed, .write_permit_latch, .ready, .deep_down,
		.erase_done, .erase_boosted);
	fbe_host #(.SETTLE_CYCLES(20)) fbe_host_i (.mclk, .nrst, .supply_ok,
		.cmd_valid, .cmd_op, .cmd_ready, .cmd_done, .rsp_byte,
		.link(lnk.host));
	fbe_checker fbe_checker_i (.mclk, .nrst, .supply_ok, .cs_n(lnk.cs_n),
		.sclk(lnk.sclk), .busy, .boost_armed, .write_permit_latch,
		.ready, .deep_down, .erase_done);
	always #4 mclk = ~mclk;
	// Length of the latest busy stretch
	always @(posedge mclk) begin
		pb <= busy;
		bcnt <= busy ? (pb ? bcnt + 1 : 1) : bcnt;
	end
	task automatic chk(input string nm, input logic [7:0] e, g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic tick();
		@(posedge mclk);
		#1;
	endtask
	task automatic wt(ref logic s);
		for (int n = 0; n < 3000 && s !== 1'b1; n++) tick();
		chk("wait", 8'h01, {7'h00, s});
	endtask
	task automatic st();
		chk("arm", 8'(armed), {7'h00, boost_armed});
		chk("permit", 8'(permit), {7'h00, write_permit_latch});
		chk("busy", 8'h00, {7'h00, busy});
	endtask
	task automatic send(input logic [7:0] o);
		wt(cmd_ready);
		cmd_op = o;
		cmd_valid = 1'b1;
		tick();
		cmd_valid = 1'b0;
		wt(cmd_done);
		repeat (3) tick();
	endtask
	task automatic erase(input int len, b);
		send(OPC_FULL_ERASE);
		wt(erase_done);
		chk("len", 8'(len), 8'(bcnt));
		chk("boost", 8'(b), {7'h00, erase_boosted});
		armed = 0;
		permit = 0;
		st();
	endtask
	task automatic close_out();
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		#(8 * 20000);
		error_cnt++;
		close_out();
	end
	initial begin
		{mclk, nrst, supply_ok, cmd_valid, cmd_op} = '0;
		seed = $urandom(68);
		repeat (20) tick();
		nrst = 1'b1;
		supply_ok = 1'b1;
		wt(ready);
		chk("deep", 8'h00, {7'h00, deep_down});
		st();
		send(OPC_BOOST_ARM);
		armed = 1;
		send(OPC_FULL_ERASE);
		repeat (3) tick();
		st();
		for (int i = 0; i < 8; i++) begin
			op = i[0] ? OPC_READ_STATUS : ($urandom_range(1)
				? OPC_WRITE_PERMIT : OPC_BOOST_ARM);
			send(op);
			if (op == OPC_WRITE_PERMIT) permit = 1;
			if (op == OPC_BOOST_ARM) armed = 1;
			if (op == OPC_READ_STATUS) begin
				exp_q.push_back({5'h00, 1'(armed), 1'(permit), 1'b0});
				chk("stat", exp_q.pop_front(), rsp_byte);
			end
			st();
		end
		send(OPC_DEEP_DOWN);
		chk("deep", 8'h01, {7'h00, deep_down});
		send(OPC_WRITE_PERMIT);
		send(OPC_READ_STATUS);
		chk("dstat", 8'h00, rsp_byte);
		st();
		send(OPC_RELEASE);
		chk("deep", 8'h00, {7'h00, deep_down});
		send(OPC_WRITE_PERMIT);
		send(OPC_BOOST_ARM);
		erase(5, 1);
		send(OPC_WRITE_PERMIT);
		erase(20, 0);
		send(OPC_WRITE_PERMIT);
		send(OPC_FULL_ERASE);
		supply_ok = 1'b0;
		repeat (3) tick();
		st();
		chk("ready", 8'h00, {7'h00, ready});
		chk("csn", 8'h01, {7'h00, lnk.cs_n});
		supply_ok = 1'b1;
		wt(ready);
		st();
		close_out();
	end
endmodule
`default_nettype wire
